//--- design/timer_flags.sv
// Purpose: Prescaled 16-bit counter with channel and overflow flags
// Assumes: Avalon-MM slave, index addressing, one clock, sync reset
// Notes:   Capture/compare datapaths sit outside and send event strobes
//
// Notes on behaviour
// - Prescale code picks 1..32, two codes reserved
// - New prescale applies at all-zero stage edge
// - Eight channel flags set by channel events
// - Channel flags cleared by writing ones
// - Fast clear: channel access clears its flag
// - Overflow flag bit 7, write one clears
// - Fast clear: counter access clears overflow flag
// - Overflow flag set on counter wrap
// - Ch7 reset at all ones suppresses overflow
// - Channel flags interrupt only when enabled
// - Overflow flag interrupts only when enabled
`timescale 1ns/1ps
module timer_flags
    import timer_flags_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    output logic             response_err,
    input  wire logic [7:0]  channel_event,
    input  wire logic        ch7_compare_hit,
    output logic [15:0]      free_running_counter,
    output logic             fast_flag_clear_all,
    output logic             channel_irq,
    output logic             overflow_irq,
    output logic             irq
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]  timer_system_control_q;   // Enable, fast clear
    logic [7:0]  channel_irq_enables_q;    // Per channel enables
    logic [7:0]  mode_ctrl_q;              // Overflow enable, ch7 reset, prescale
    logic [7:0]  channel_event_flags_q;    // Channel flags
    logic        overflow_flag_q;          // Overflow flag
    logic [15:0] count_q;                  // Free-running counter
    logic [15:0] ch7_compare_q;            // Channel 7 compare copy
    logic [1:0]  status_q;                 // Sticky irq status
    logic [1:0]  enable_q;                 // Status enables
    logic        ack_q;                    // One answer per request
    logic [31:0] rdata_q;                  // Read data
    logic        err_q;                    // Unmapped access
    logic        ch_irq_q;                 // Channel irq output
    logic        ovf_irq_q;                // Overflow irq output
    logic        irq_q;                    // Combined irq output
    logic [2:0]  prescale_code_q;          // Legal prescale code

    // Handshake, decode and counter helpers
    logic        req;                      // Request pending
    logic        acc;                      // Access completes this edge
    logic        wr_acc;                   // Write completes this edge
    logic        rd_acc;                   // Read completes this edge
    logic        tick;                     // Counter advance
    logic [7:0]  wbyte;                    // Write byte lane 0
    logic        fast_clear;               // Fast clear active
    logic [7:0]  ch_fast_clr;              // Fast clear per channel
    logic        cnt_access;               // Counter accessed
    logic        wrap;                     // Counter wraps
    logic        ch7_reset;                // Counter reset by ch7

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] idx);
        is_addr = (a == idx);
    endfunction : is_addr

    function automatic logic [2:0] chan_of(input logic [7:0] a);
        chan_of = a[3:1];
    endfunction : chan_of

    function automatic logic mapped(input logic [7:0] a);
        mapped = is_addr(a, IDX_CNT_HI)     || is_addr(a, IDX_CNT_LO)    ||
                 is_addr(a, IDX_SYS_CTRL)   || is_addr(a, IDX_CH_IRQ_EN) ||
                 is_addr(a, IDX_MODE_CTRL)  || is_addr(a, IDX_CH_FLAGS)  ||
                 is_addr(a, IDX_OVF_FLAG)   || is_addr(a, IDX_IRQ_STATUS) ||
                 is_addr(a, IDX_IRQ_CLEAR)  || is_addr(a, IDX_IRQ_ENABLE) ||
                 is_addr(a, IDX_CH7_CMP_HI) || is_addr(a, IDX_CH7_CMP_LO);
    endfunction : mapped

    // ------------------------------------------------------------
    // Bus handshake: one wait cycle, then ack
    // ------------------------------------------------------------
    assign req    = read || write;
    assign acc    = req && ack_q;
    assign wr_acc = write && ack_q;
    assign rd_acc = read && ack_q;
    assign wbyte  = byteenable[0] ? writedata[7:0] : RST_BYTE;

    // Waitrequest low for exactly the completing cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req && !ack_q;
        end
    end

    // Waitrequest mirrors the not-yet-acknowledged state
    always_ff @(posedge clk) begin
        if (rst) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= !(req && !ack_q);
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            timer_system_control_q <= RST_BYTE;
            channel_irq_enables_q  <= RST_BYTE;
            mode_ctrl_q            <= RST_BYTE;
            ch7_compare_q          <= 16'h0000;
            enable_q               <= 2'h0;
        end else if (wr_acc && byteenable[0]) begin
            if (is_addr(address, IDX_SYS_CTRL)) begin
                timer_system_control_q <= {wbyte[7:4], 4'h0};
            end
            if (is_addr(address, IDX_CH_IRQ_EN)) begin
                channel_irq_enables_q <= wbyte;
            end
            if (is_addr(address, IDX_MODE_CTRL)) begin
                mode_ctrl_q <= {wbyte[7], 1'b0, wbyte[5:0]};
            end
            if (is_addr(address, IDX_CH7_CMP_HI)) begin
                ch7_compare_q[15:8] <= wbyte;
            end
            if (is_addr(address, IDX_CH7_CMP_LO)) begin
                ch7_compare_q[7:0] <= wbyte;
            end
            if (is_addr(address, IDX_IRQ_ENABLE)) begin
                enable_q <= wbyte[1:0];
            end
        end
    end

    // Reserved codes keep the last legal selection
    always_ff @(posedge clk) begin
        if (rst) begin
            prescale_code_q <= 3'h0;
        end else if (mode_ctrl_q[2:0] <= PRESCALE_MAX) begin
            prescale_code_q <= mode_ctrl_q[2:0];
        end
    end

    // ------------------------------------------------------------
    // Prescaler and free-running counter
    // ------------------------------------------------------------
    timer_prescaler u_prescaler (
        .clk      (clk),
        .rst      (rst),
        .run      (timer_system_control_q[7]),
        .sel_code (prescale_code_q),
        .tick     (tick)
    );

    assign ch7_reset = mode_ctrl_q[POS_CH7_RESET] && ch7_compare_hit;
    // A ch7 reset at all ones takes the wrap path without flagging
    assign wrap = tick && (count_q == 16'hffff) && !ch7_reset;

    // Counter advance or ch7 compare reset
    always_ff @(posedge clk) begin
        if (rst) begin
            count_q <= 16'h0000;
        end else if (ch7_reset && tick) begin
            count_q <= 16'h0000;
        end else if (tick) begin
            count_q <= count_q + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Fast clear decode
    // ------------------------------------------------------------
    assign fast_clear = timer_system_control_q[POS_FAST_CLEAR];
    assign cnt_access = acc && (is_addr(address, IDX_CNT_HI) || is_addr(address, IDX_CNT_LO));

    // Channel access: read or write clears that channel
    always_comb begin
        ch_fast_clr = 8'h00;
        if (fast_clear && acc && address >= IDX_CH_FIRST && address <= IDX_CH_LAST) begin
            ch_fast_clr[chan_of(address)] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Channel flags: set wins over clear
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            channel_event_flags_q <= RST_BYTE;
        end else begin
            channel_event_flags_q <= (channel_event_flags_q
                & ~((wr_acc && is_addr(address, IDX_CH_FLAGS)) ? wbyte : 8'h00)
                & ~ch_fast_clr)
                | channel_event;
        end
    end

    // ------------------------------------------------------------
    // Overflow flag: set wins over clear
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            overflow_flag_q <= 1'b0;
        end else if (wrap) begin
            overflow_flag_q <= 1'b1;
        end else if (wr_acc && is_addr(address, IDX_OVF_FLAG) && wbyte[POS_OVF_FLAG]) begin
            overflow_flag_q <= 1'b0;
        end else if (fast_clear && cnt_access) begin
            overflow_flag_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Interrupt outputs and sticky status
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            ch_irq_q  <= 1'b0;
            ovf_irq_q <= 1'b0;
            irq_q     <= 1'b0;
        end else begin
            ch_irq_q  <= |(channel_event_flags_q & channel_irq_enables_q);
            ovf_irq_q <= overflow_flag_q && mode_ctrl_q[POS_OVF_IRQ_EN];
            irq_q     <= |(status_q & enable_q);
        end
    end

    // Status latches irq requests; new event beats a clear
    always_ff @(posedge clk) begin
        if (rst) begin
            status_q <= 2'h0;
        end else begin
            status_q <= (status_q
                & ~((wr_acc && is_addr(address, IDX_IRQ_CLEAR)) ? wbyte[1:0] : 2'h0))
                | {ovf_irq_q, ch_irq_q};
        end
    end

    // ------------------------------------------------------------
    // Read data and error answer
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
            err_q   <= 1'b0;
        end else if (req && !ack_q) begin
            err_q   <= !mapped(address) && !(address >= IDX_CH_FIRST && address <= IDX_CH_LAST);
            rdata_q <= 32'h0000_0000;
            if (read) begin
                case (address)
                    IDX_CNT_HI:     rdata_q[7:0] <= count_q[15:8];
                    IDX_CNT_LO:     rdata_q[7:0] <= count_q[7:0];
                    IDX_SYS_CTRL:   rdata_q[7:0] <= timer_system_control_q;
                    IDX_CH_IRQ_EN:  rdata_q[7:0] <= channel_irq_enables_q;
                    IDX_MODE_CTRL:  rdata_q[7:0] <= mode_ctrl_q;
                    IDX_CH_FLAGS:   rdata_q[7:0] <= channel_event_flags_q;
                    IDX_OVF_FLAG:   rdata_q[7:0] <= {overflow_flag_q, 7'h00};
                    IDX_IRQ_STATUS: rdata_q[1:0] <= status_q;
                    IDX_IRQ_ENABLE: rdata_q[1:0] <= enable_q;
                    IDX_CH7_CMP_HI: rdata_q[7:0] <= ch7_compare_q[15:8];
                    IDX_CH7_CMP_LO: rdata_q[7:0] <= ch7_compare_q[7:0];
                    default:        rdata_q      <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Output drives
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            free_running_counter <= 16'h0000;
            fast_flag_clear_all  <= 1'b0;
        end else begin
            free_running_counter <= count_q;
            fast_flag_clear_all  <= fast_clear;
        end
    end

    assign readdata     = rdata_q;
    assign response_err = err_q;
    assign channel_irq  = ch_irq_q;
    assign overflow_irq = ovf_irq_q;
    assign irq          = irq_q;

endmodule : timer_flags

//--- design/timer_flags_pkg.sv
// Purpose: Shared constants for the timer prescaler and flag block
// Assumes: 8-bit register data in the low bits of a 32-bit Avalon word
// Notes:   Offsets are register indexes; byte address is four times index
package timer_flags_pkg;

    // ------------------------------------------------------------
    // Register indexes
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_CNT_HI      = 8'h84;  // Counter high byte
    localparam logic [7:0] IDX_CNT_LO      = 8'h85;  // Counter low byte
    localparam logic [7:0] IDX_SYS_CTRL    = 8'h86;  // Timer system control
    localparam logic [7:0] IDX_CH_IRQ_EN   = 8'h8c;  // Channel irq enables
    localparam logic [7:0] IDX_MODE_CTRL   = 8'h8d;  // Overflow irq, ch7 reset, prescale
    localparam logic [7:0] IDX_CH_FLAGS    = 8'h8e;  // Channel event flags
    localparam logic [7:0] IDX_OVF_FLAG    = 8'h8f;  // Counter overflow flag
    localparam logic [7:0] IDX_CH_FIRST    = 8'h90;  // First channel register
    localparam logic [7:0] IDX_CH_LAST     = 8'h9f;  // Last channel register
    localparam logic [7:0] IDX_IRQ_STATUS  = 8'hc0;  // Sticky event status
    localparam logic [7:0] IDX_IRQ_CLEAR   = 8'hc1;  // Write-one clear of status
    localparam logic [7:0] IDX_IRQ_ENABLE  = 8'hc2;  // Enable of status bits
    localparam logic [7:0] IDX_CH7_CMP_HI  = 8'hc4;  // Channel 7 compare high byte
    localparam logic [7:0] IDX_CH7_CMP_LO  = 8'hc5;  // Channel 7 compare low byte

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int         POS_FAST_CLEAR  = 4;      // Fast flag clear in system ctrl
    localparam int         POS_OVF_IRQ_EN  = 7;      // Overflow irq enable
    localparam int         POS_CH7_RESET   = 3;      // Counter reset on ch7 compare
    localparam int         POS_OVF_FLAG    = 7;      // Overflow flag bit
    localparam logic [7:0] RST_BYTE        = 8'h00;  // Reset value of all registers
    localparam logic [2:0] PRESCALE_MAX    = 3'h5;   // Highest legal prescale code
    localparam int         PRESCALE_BITS   = 5;      // Divider stages
    localparam int         EV_CHANNEL      = 0;      // Status bit: channel irq
    localparam int         EV_OVERFLOW     = 1;      // Status bit: overflow irq

endpackage : timer_flags_pkg

//--- design/timer_prescaler.sv
// Purpose: Divide-by-two stage prescaler for the free-running counter
// Assumes: Code already checked legal by the caller
// Notes:   New code is applied only when all stages are zero
`timescale 1ns/1ps
module timer_prescaler
    import timer_flags_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       run,
    input  wire logic [2:0] sel_code,
    output logic            tick
);

    // Divider stages and active division code
    logic [PRESCALE_BITS-1:0] stage_q;
    logic [2:0]               active_q;
    logic [PRESCALE_BITS-1:0] mask;

    // ------------------------------------------------------------
    // Terminal mask of the active code
    // ------------------------------------------------------------
    always_comb begin
        mask = PRESCALE_BITS'((6'h01 << active_q) - 6'h01);
    end

    // Tick when the low active stages are all ones
    assign tick = run && ((stage_q & mask) == mask);

    // ------------------------------------------------------------
    // Stage counter
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            stage_q <= '0;
        end else if (run) begin
            stage_q <= stage_q + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Deferred code update at an all-zero stage edge
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            active_q <= 3'h0;
        end else if (run && (stage_q + 1'b1) == '0) begin
            active_q <= sel_code;
        end
    end

endmodule : timer_prescaler

//--- testbench/timer_flags_assertions.sv
// Purpose: Port checks on the timer flag block
// Assumes: One clock, synchronous active-high reset, two-cycle bus answer
// Notes:   Flag contents are checked by bench reads
`timescale 1ns/1ps
module timer_flags_assertions
    import timer_flags_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        response_err,
    input wire logic [7:0]  channel_event,
    input wire logic        ch7_compare_hit,
    input wire logic [15:0] free_running_counter,
    input wire logic        fast_flag_clear_all,
    input wire logic        channel_irq,
    input wire logic        overflow_irq,
    input wire logic        irq
);
    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    logic [15:0] cnt_prev_q;  // Counter copy one cycle back
    logic [3:0]  ch_hist_q;   // Recent channel events or writes
    logic [3:0]  ovf_hist_q;  // Recent wraps or writes
    logic [3:0]  wr_hist_q;   // Recent completed writes
    logic        wrap_now;    // Counter copy just wrapped
    logic        done_wr;     // Write completing this cycle
    logic        mapped;      // Index decodes to a register
    assign wrap_now = (cnt_prev_q == 16'hffff) && (free_running_counter == 16'h0000);
    assign done_wr  = write && !waitrequest;
    assign mapped   = address inside {[IDX_CNT_HI:IDX_SYS_CTRL], [IDX_CH_IRQ_EN:IDX_OVF_FLAG],
                      [IDX_CH_FIRST:IDX_CH_LAST], [IDX_IRQ_STATUS:IDX_IRQ_ENABLE],
                      [IDX_CH7_CMP_HI:IDX_CH7_CMP_LO]};
    // Cause histories, four cycles deep
    always_ff @(posedge clk) begin
        cnt_prev_q <= free_running_counter;
        ch_hist_q  <= {ch_hist_q[2:0], (|channel_event) || done_wr};
        ovf_hist_q <= {ovf_hist_q[2:0], wrap_now || done_wr};
        wr_hist_q  <= {wr_hist_q[2:0], done_wr};
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_wait_single: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low too long");
    a_answer_delay: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
        else $error("bus answer not after two cycles");
    a_err_decode: assert property (!waitrequest && (read || write) |->
        response_err == !mapped && (!(read && response_err) || readdata == 32'h0))
        else $error("error response off the decode");
    a_ovf_low_zero: assert property (!waitrequest && read && address == IDX_OVF_FLAG |->
        readdata[6:0] == 7'h00)
        else $error("overflow register low bits not zero");
    a_count_step: assert property (free_running_counter != $past(free_running_counter) |->
        free_running_counter == $past(free_running_counter) + 16'h1
        || free_running_counter == 16'h0000)
        else $error("counter skipped a value");
    a_chirq_cause: assert property ($rose(channel_irq) |-> |ch_hist_q)
        else $error("channel irq rose without cause");
    a_ovirq_cause: assert property ($rose(overflow_irq) |-> wrap_now || |ovf_hist_q)
        else $error("overflow irq rose without cause");
    a_irq_sticky: assert property ($fell(irq) |-> |wr_hist_q)
        else $error("irq fell without a write");
    c_overflow: cover property ($rose(overflow_irq));
    c_irq: cover property ($rose(irq));
    c_err: cover property (!waitrequest && response_err);
endmodule : timer_flags_assertions

bind timer_flags timer_flags_assertions u_chk (.clk(clk), .rst(rst), .address(address),
    .read(read), .write(write),
    .readdata(readdata), .waitrequest(waitrequest), .response_err(response_err),
    .channel_event(channel_event), .ch7_compare_hit(ch7_compare_hit),
    .free_running_counter(free_running_counter), .fast_flag_clear_all(fast_flag_clear_all),
    .channel_irq(channel_irq), .overflow_irq(overflow_irq), .irq(irq));

//--- testbench/timer_flags_bench.sv
// Purpose: Self-checking bench for the timer prescaler and flag block
// Assumes: Two-cycle bus answer, 100 MHz clock, synchronous reset
// Notes:   One counter wrap at divide by one takes about 66k cycles
`timescale 1ns/1ps
module timer_flags_bench
    import timer_flags_pkg::*;
;
    logic        clk, rst, read, write, waitrequest, response_err, ch7_compare_hit;
    logic        fast_flag_clear_all, channel_irq, overflow_irq, irq;
    logic [7:0]  address, channel_event;
    logic [31:0] writedata, readdata;
    logic [3:0]  byteenable;
    logic [15:0] free_running_counter;
    logic [31:0] rng_q = 32'hc2b1e742; // Xorshift state
    logic [40:0] exp_q[$];  // Expected reads: index, error, data
    logic [40:0] e;         // Entry taken by the monitor
    int          n_errors = 0, tests_run = 0;

    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    timer_flags DUT (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .response_err(response_err), .channel_event(channel_event),
        .ch7_compare_hit(ch7_compare_hit), .free_running_counter(free_running_counter),
        .fast_flag_clear_all(fast_flag_clear_all), .channel_irq(channel_irq),
        .overflow_irq(overflow_irq), .irq(irq));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    task automatic close_out();
        if (n_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One bus cycle; reads leave their expectation for the monitor
    task automatic bus(input logic rd, input logic [7:0] a, input logic [7:0] d,
                       input logic [7:0] x, input logic er);
        int k;
        @(posedge clk);
        read      <= rd;
        write     <= !rd;
        address   <= a;
        writedata <= {24'h0, d};
        if (rd) begin
            exp_q.push_back({a, er, 24'h0, x});
        end
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (waitrequest === 1'b0) break;
        end
        if (k == 20) begin
            chk("bus answer", 32'h0, 32'h1);
            close_out();
        end
        read  <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b0, a, d, 8'h00, 1'b0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        bus(1'b1, a, 8'h00, x, 1'b0);
    endtask : rd

    // One-cycle pulse on the channel event strobes
    task automatic pulse(input logic [7:0] p);
        @(posedge clk);
        channel_event <= p;
        @(posedge clk);
        channel_event <= 8'h00;
    endtask : pulse

    // Cycles until the counter copy next changes
    task automatic gap(output int n);
        logic [15:0] c0;
        c0 = free_running_counter;
        for (n = 1; n < 100; n++) begin
            @(posedge clk);
            if (free_running_counter !== c0) break;
        end
    endtask : gap

    // Monitor: compares each read answer with the oldest note
    always @(posedge clk) begin
        if (rst === 1'b0 && waitrequest === 1'b0 && read === 1'b1) begin
            e = exp_q.pop_front();
            chk($sformatf("readdata at %h", e[40:33]), e[31:0], readdata);
            chk("response_err", 32'(e[32]), 32'(response_err));
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int i;
        int n;
        logic [7:0] f;
        rst = 1'b1;
        {read, write, ch7_compare_hit, address, writedata, channel_event} = '0;
        byteenable = 4'hf;
        f = 8'h00;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(IDX_CH_FLAGS, RST_BYTE);
        rd(IDX_OVF_FLAG, RST_BYTE);
        bus(1'b1, 8'h10, 8'h00, 8'h00, 1'b1);
        wr(8'h10, 8'hff);
        // Random events and write-one clears
        for (i = 0; i < 6; i++) begin
            rng_q = xs(rng_q);
            pulse(rng_q[7:0]);
            f = f | rng_q[7:0];
            rd(IDX_CH_FLAGS, f);
            wr(IDX_CH_FLAGS, rng_q[15:8]);
            f = f & ~rng_q[15:8];
            rd(IDX_CH_FLAGS, f);
        end
        byteenable <= 4'h0;
        wr(IDX_CH_FLAGS, 8'hff);
        byteenable <= 4'hf;
        rd(IDX_CH_FLAGS, f);
        // Each channel masked then enabled
        for (i = 0; i < 8; i++) begin
            wr(IDX_CH_FLAGS, 8'hff);
            pulse(8'h01 << i);
            wr(IDX_CH_IRQ_EN, ~(8'h01 << i));
            repeat (3) @(posedge clk);
            chk("channel_irq", 32'h0, {31'h0, channel_irq});
            wr(IDX_CH_IRQ_EN, 8'h01 << i);
            repeat (3) @(posedge clk);
            chk("channel_irq", 32'h1, {31'h0, channel_irq});
        end
        // Status, mask and clear of the interrupt output
        wr(IDX_IRQ_ENABLE, 8'h01);
        repeat (3) @(posedge clk);
        chk("irq", 32'h1, {31'h0, irq});
        rd(IDX_IRQ_STATUS, 8'h01);
        wr(IDX_IRQ_ENABLE, 8'h00);
        repeat (3) @(posedge clk);
        chk("irq", 32'h0, {31'h0, irq});
        wr(IDX_CH_FLAGS, 8'hff);
        wr(IDX_IRQ_CLEAR, 8'h01);
        wr(IDX_IRQ_ENABLE, 8'h01);
        repeat (3) @(posedge clk);
        chk("irq", 32'h0, {31'h0, irq});
        rd(IDX_IRQ_STATUS, 8'h00);
        // Channel accesses clear flags only in fast mode
        pulse(8'hff);
        rd(8'h92, 8'h00);
        rd(IDX_CH_FLAGS, 8'hff);
        wr(IDX_SYS_CTRL, 8'h10);
        repeat (2) @(posedge clk);
        chk("fast_flag_clear_all", 32'h1, {31'h0, fast_flag_clear_all});
        rd(8'h92, 8'h00);
        wr(8'h9f, 8'h00);
        rd(IDX_CH_FLAGS, 8'h7d);
        // Prescale periods, reserved code keeps the last legal one
        wr(IDX_SYS_CTRL, 8'h80);
        for (i = 0; i < 7; i++) begin
            wr(IDX_MODE_CTRL, i[7:0]);
            repeat (40) gap(n);
            gap(n);
            chk("prescale period", (i > 5) ? 32'd32 : 32'd1 << i, n);
        end
        // Counter wrap at divide by one
        wr(IDX_MODE_CTRL, 8'h00);
        for (i = 0; i < 70000 && free_running_counter !== 16'hffff; i++) begin
            @(posedge clk);
        end
        chk("counter top", 32'hffff, {16'h0, free_running_counter});
        repeat (4) @(posedge clk);
        rd(IDX_OVF_FLAG, 8'h80);
        wr(IDX_OVF_FLAG, 8'h7f);
        rd(IDX_OVF_FLAG, 8'h80);
        wr(IDX_MODE_CTRL, 8'h80);
        repeat (3) @(posedge clk);
        chk("overflow_irq", 32'h1, {31'h0, overflow_irq});
        wr(IDX_MODE_CTRL, 8'h00);
        repeat (3) @(posedge clk);
        chk("overflow_irq", 32'h0, {31'h0, overflow_irq});
        wr(IDX_SYS_CTRL, 8'h90);
        wr(IDX_CNT_LO, 8'h00);
        rd(IDX_OVF_FLAG, 8'h00);
        repeat (3) @(posedge clk);
        close_out();
    end
endmodule : timer_flags_bench
